//--- logic/nsf_pkg.sv
// Constants, types and register map of the navigation subframe framer.
// Assumes a 20 MHz APB clock and software that fills the clock data set.
`default_nettype none
package nsf_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned BIT_TIME_NS = 20_000_000;
  localparam int unsigned BIT_CYCLES = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned EPOCH_TIME_MS = 1500;
  localparam int unsigned BIT_TIME_MS = 20;
  localparam int unsigned EPOCH_BITS = EPOCH_TIME_MS / BIT_TIME_MS;
  localparam logic [18:0] TOW_MAX = 19'h626ff;
  localparam logic [19:0] TOW_WEEK = 20'h62700;
  localparam logic [19:0] SUBFRAME_EPOCHS = 20'h00004;
  localparam logic [4:0] WORD_LAST_BIT = 5'h1d;
  localparam logic [3:0] WORDS_PER_SUBFRAME = 4'ha;
  localparam logic [2:0] SUBFRAME_LAST = 3'h5;
  // Arbitrary neutral preamble value
  localparam logic [7:0] PREAMBLE_DEF = 8'ha5;

  // ----------------------------------------
  // Parity masks, data bit 1 in the msb
  // ----------------------------------------
  localparam logic [23:0] PAR_MASK_25 = 24'hec7cd2;
  localparam logic [23:0] PAR_MASK_26 = 24'h763e69;
  localparam logic [23:0] PAR_MASK_27 = 24'hbb1f34;
  localparam logic [23:0] PAR_MASK_28 = 24'h5d8f9a;
  localparam logic [23:0] PAR_MASK_29 = 24'haec7cd;
  localparam logic [23:0] PAR_MASK_30 = 24'h2dea27;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_WEEK = 8'h08;
  localparam logic [7:0] OFS_TOW = 8'h0c;
  localparam logic [7:0] OFS_CLK_HEALTH = 8'h10;
  localparam logic [7:0] OFS_GROUP_DELAY = 8'h14;
  localparam logic [7:0] OFS_CLK_REF = 8'h18;
  localparam logic [7:0] OFS_DRIFT = 8'h1c;
  localparam logic [7:0] OFS_BIAS = 8'h20;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int unsigned CTRL_UPLOAD_END_BIT = 5;
  localparam int unsigned CTRL_COMMIT_BIT = 6;
  localparam int unsigned STATUS_ERR_BIT = 2;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [9:0] WEEK_RST = 10'h000;
  localparam logic [18:0] TOW_RST = 19'h00000;
  localparam logic [2:0] SUBFRAME_RST = 3'h1;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic {ST_IDLE, ST_SEND} nsf_tx_state_t;

  typedef struct packed {
    logic antispoof;
    logic sync_lost;
    logic alert;
    logic cfg001;
    logic enable;
  } nsf_ctrl_t;

  typedef struct packed {
    logic [3:0] grade;
    logic [5:0] health;
    logic [9:0] issue;
    logic [7:0] gdelay;
    logic [15:0] tref;
    logic [7:0] drate;
    logic [15:0] drift;
    logic [21:0] bias;
  } nsf_clk_set_t;

endpackage
`default_nettype wire

//--- logic/nsf_parity.sv
// Word parity encoder for one 30-bit navigation word.
// Assumes the caller feeds the last two bits of the previous word.
`timescale 1ns/100ps
`default_nettype none
module nsf_parity (
  input wire logic [23:0] data,
  input wire logic d29_prev,
  input wire logic d30_prev,
  output logic [29:0] word
);

  // ----------------------------------------
  // Parity bits and data inversion
  // ----------------------------------------
  logic [5:0] par;

  always_comb begin
    par[5] = d29_prev ^ (^(data & nsf_pkg::PAR_MASK_25));
    par[4] = d30_prev ^ (^(data & nsf_pkg::PAR_MASK_26));
    par[3] = d29_prev ^ (^(data & nsf_pkg::PAR_MASK_27));
    par[2] = d30_prev ^ (^(data & nsf_pkg::PAR_MASK_28));
    par[1] = d30_prev ^ (^(data & nsf_pkg::PAR_MASK_29));
    par[0] = d29_prev ^ (^(data & nsf_pkg::PAR_MASK_30));
    word = {data ^ {24{d30_prev}}, par};
  end

endmodule
`default_nettype wire

//--- logic/nsf_framer.sv
// Navigation subframe framer: serial 50 bit/s word stream with APB registers.
// Assumes pclk at 20 MHz and software that loads week, count and clock data.
// Operation
// - Config 000: bit 18 set by thruster dump, cleared when upload ends.
// - Config 001: bit 18 is the alert flag from software.
// - Config 000: bit 19 is the synchronisation lost flag.
// - Config 001: bit 19 shows anti-spoof mode active.
// - Handover bits 20-22 carry subframe number one to five.
// - Word three top ten bits carry week number.
// - Week number advances at every end of week.
// - Word three bits 13-16 carry range error grade.
// - Grade value is the worst expected over the validity period.
// - Word three bits 17-22 carry health, msb summarising data health.
// - Low health bits report signal health; absent capability reads healthy.
// - Issue number split: two msbs word three, eight lsbs word eight.
// - New clock issue number must differ from recent ones; the commit only rejects a match with the active issue.
// - Word seven bits 17-24 carry group delay term.
// - Words eight to ten carry reference time, drift rate, drift, bias.
// - Reserved fields still carry valid word parity.
// - Clock data stays fixed through its transmission interval.
// - Ten 30-bit words per subframe, msb first, six parity lsbs.
// - Handover word starts with 17 msbs of next subframe count.
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module nsf_framer #(
  parameter int unsigned BIT_CYCLES = nsf_pkg::BIT_CYCLES,
  parameter logic [7:0] PREAMBLE = nsf_pkg::PREAMBLE_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic momentum_dump,
  output logic nav_bit,
  output logic bit_strobe,
  output logic word_start,
  output logic [3:0] word_index,
  output logic [2:0] subframe_id
);

  localparam int unsigned DIV_W = $clog2(BIT_CYCLES + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BIT_CYCLES - 1);
  localparam logic [6:0] EPOCH_LAST = 7'(nsf_pkg::EPOCH_BITS - 1);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  nsf_pkg::nsf_ctrl_t ctrl_r, ctrl_nxt;
  nsf_pkg::nsf_clk_set_t staged_r, staged_nxt, active_r, active_nxt;
  logic dump_r, dump_nxt, pend_r, pend_nxt, err_r, err_nxt;
  logic [9:0] week_r, week_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic setup, wr, mapped, tow_wr, commit_req, upload_end;
  logic [31:0] rd_mux;

  // ----------------------------------------
  // Transmit state
  // ----------------------------------------
  nsf_pkg::nsf_tx_state_t state_r, state_nxt;
  logic [DIV_W-1:0] div_r, div_nxt;
  logic [4:0] bit_cnt_r, bit_cnt_nxt;
  logic [3:0] word_idx_r, word_idx_nxt;
  logic [2:0] sf_r, sf_nxt;
  logic [6:0] ebit_r, ebit_nxt;
  logic [18:0] tow_r, tow_nxt;
  logic [29:0] tx_word_r, tx_word_nxt;
  logic [23:0] tx_data_r, tx_data_nxt, build;
  logic load_r, load_nxt, strobe_r, strobe_nxt, wstart_r, wstart_nxt;
  logic d29p_r, d29p_nxt, d30p_r, d30p_nxt;
  logic bit_tick, week_inc, frame_swap, flag18, flag19;
  logic [19:0] tow_sum;
  logic [18:0] tow_how;
  logic [29:0] par_word;

  // ----------------------------------------
  // APB slave and registers
  // ----------------------------------------
  always_comb begin
    setup = psel && !penable;
    wr = psel && penable && pready_r && pwrite;
    mapped = 1'b1;
    rd_mux = 32'h0;
    case (paddr)
      nsf_pkg::OFS_CTRL: rd_mux = {27'h0, ctrl_r};
      nsf_pkg::OFS_STATUS: rd_mux = {21'h0, state_r == nsf_pkg::ST_SEND, word_idx_r, sf_r, err_r, pend_r, dump_r};
      nsf_pkg::OFS_WEEK: rd_mux = {22'h0, week_r};
      nsf_pkg::OFS_TOW: rd_mux = {13'h0, tow_r};
      nsf_pkg::OFS_CLK_HEALTH: rd_mux = {12'h0, staged_r.issue, staged_r.health, staged_r.grade};
      nsf_pkg::OFS_GROUP_DELAY: rd_mux = {24'h0, staged_r.gdelay};
      nsf_pkg::OFS_CLK_REF: rd_mux = {16'h0, staged_r.tref};
      nsf_pkg::OFS_DRIFT: rd_mux = {8'h0, staged_r.drift, staged_r.drate};
      nsf_pkg::OFS_BIAS: rd_mux = {10'h0, staged_r.bias};
      default: mapped = 1'b0;
    endcase
    pready_nxt = setup;
    pslverr_nxt = setup && !mapped;
    prdata_nxt = setup ? rd_mux : prdata_r;
    ctrl_nxt = ctrl_r;
    staged_nxt = staged_r;
    active_nxt = active_r;
    week_nxt = week_r;
    pend_nxt = pend_r;
    err_nxt = err_r;
    tow_wr = 1'b0;
    commit_req = 1'b0;
    upload_end = 1'b0;
    if (wr) begin
      case (paddr)
        nsf_pkg::OFS_CTRL: begin
          ctrl_nxt = pwdata[4:0];
          upload_end = pwdata[nsf_pkg::CTRL_UPLOAD_END_BIT];
          commit_req = pwdata[nsf_pkg::CTRL_COMMIT_BIT];
        end
        nsf_pkg::OFS_STATUS: begin
          if (pwdata[nsf_pkg::STATUS_ERR_BIT]) begin
            err_nxt = 1'b0;
          end
        end
        nsf_pkg::OFS_WEEK: week_nxt = pwdata[9:0];
        nsf_pkg::OFS_TOW: tow_wr = (state_r == nsf_pkg::ST_IDLE);
        nsf_pkg::OFS_CLK_HEALTH: begin
          staged_nxt.grade = pwdata[3:0];
          staged_nxt.health = pwdata[9:4];
          staged_nxt.issue = pwdata[19:10];
        end
        nsf_pkg::OFS_GROUP_DELAY: staged_nxt.gdelay = pwdata[7:0];
        nsf_pkg::OFS_CLK_REF: staged_nxt.tref = pwdata[15:0];
        nsf_pkg::OFS_DRIFT: begin
          staged_nxt.drate = pwdata[7:0];
          staged_nxt.drift = pwdata[23:8];
        end
        nsf_pkg::OFS_BIAS: staged_nxt.bias = pwdata[21:0];
        default: ;
      endcase
    end
    if (week_inc) begin
      week_nxt = week_nxt + 10'h001;
    end
    if (frame_swap && pend_r) begin
      active_nxt = staged_r;
      pend_nxt = 1'b0;
    end
    if (commit_req) begin
      if (staged_r.issue == active_r.issue) begin
        err_nxt = 1'b1;
      end else begin
        pend_nxt = 1'b1;
      end
    end
    dump_nxt = momentum_dump ? 1'b1 : (upload_end ? 1'b0 : dump_r);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= '0;
      staged_r <= '0;
      active_r <= '0;
      week_r <= nsf_pkg::WEEK_RST;
      dump_r <= 1'b0;
      pend_r <= 1'b0;
      err_r <= 1'b0;
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      staged_r <= staged_nxt;
      active_r <= active_nxt;
      week_r <= week_nxt;
      dump_r <= dump_nxt;
      pend_r <= pend_nxt;
      err_r <= err_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ----------------------------------------
  // Word builder
  // ----------------------------------------
  always_comb begin
    tow_sum = {1'b0, tow_r} + nsf_pkg::SUBFRAME_EPOCHS;
    if (tow_sum >= nsf_pkg::TOW_WEEK) begin
      tow_sum = tow_sum - nsf_pkg::TOW_WEEK;
    end
    tow_how = tow_sum[18:0];
    flag18 = ctrl_r.cfg001 ? ctrl_r.alert : dump_r;
    flag19 = ctrl_r.cfg001 ? ctrl_r.antispoof : ctrl_r.sync_lost;
    build = 24'h0;
    case (word_idx_r)
      4'h1: build = {PREAMBLE, 16'h0};
      4'h2: build = {tow_how[18:2], flag18, flag19, sf_r, 2'b00};
      4'h3: build = {week_r, 2'b00, active_r.grade, active_r.health, active_r.issue[9:8]};
      4'h7: build = {16'h0, active_r.gdelay};
      4'h8: build = {active_r.issue[7:0], active_r.tref};
      4'h9: build = {active_r.drate, active_r.drift};
      4'ha: build = {active_r.bias, 2'b00};
      default: build = 24'h0;
    endcase
    if (sf_r != 3'h1 && word_idx_r > 4'h2) begin
      build = 24'h0;
    end
  end

  nsf_parity u_parity (
    .data(build),
    .d29_prev(d29p_r),
    .d30_prev(d30p_r),
    .word(par_word)
  );

  // ----------------------------------------
  // Bit timing and sequencing
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    div_nxt = div_r;
    bit_cnt_nxt = bit_cnt_r;
    word_idx_nxt = word_idx_r;
    sf_nxt = sf_r;
    ebit_nxt = ebit_r;
    tow_nxt = tow_r;
    tx_word_nxt = tx_word_r;
    tx_data_nxt = tx_data_r;
    d29p_nxt = d29p_r;
    d30p_nxt = d30p_r;
    load_nxt = 1'b0;
    week_inc = 1'b0;
    frame_swap = 1'b0;
    bit_tick = (state_r == nsf_pkg::ST_SEND) && (div_r == DIV_LAST);
    case (state_r)
      nsf_pkg::ST_IDLE: begin
        div_nxt = '0;
        if (tow_wr) begin
          tow_nxt = pwdata[18:0];
        end
        if (ctrl_r.enable) begin
          state_nxt = nsf_pkg::ST_SEND;
          load_nxt = 1'b1;
          word_idx_nxt = 4'h1;
          bit_cnt_nxt = 5'h0;
          ebit_nxt = 7'h0;
          frame_swap = (sf_r == 3'h1);
        end
      end
      nsf_pkg::ST_SEND: begin
        div_nxt = bit_tick ? '0 : div_r + DIV_W'(1);
        if (!ctrl_r.enable) begin
          state_nxt = nsf_pkg::ST_IDLE;
        end else if (bit_tick) begin
          if (ebit_r == EPOCH_LAST) begin
            ebit_nxt = 7'h0;
            week_inc = (tow_r == nsf_pkg::TOW_MAX);
            tow_nxt = week_inc ? 19'h0 : tow_r + 19'h00001;
          end else begin
            ebit_nxt = ebit_r + 7'h01;
          end
          if (bit_cnt_r == nsf_pkg::WORD_LAST_BIT) begin
            bit_cnt_nxt = 5'h0;
            load_nxt = 1'b1;
            if (word_idx_r == nsf_pkg::WORDS_PER_SUBFRAME) begin
              word_idx_nxt = 4'h1;
              sf_nxt = (week_inc || sf_r == nsf_pkg::SUBFRAME_LAST) ? 3'h1 : sf_r + 3'h1;
              frame_swap = (sf_nxt == 3'h1);
            end else begin
              word_idx_nxt = word_idx_r + 4'h1;
            end
          end else begin
            bit_cnt_nxt = bit_cnt_r + 5'h01;
            tx_word_nxt = {tx_word_r[28:0], 1'b0};
          end
        end
      end
      default: state_nxt = nsf_pkg::ST_IDLE;
    endcase
    if (load_r) begin
      tx_word_nxt = par_word;
      tx_data_nxt = build;
      d29p_nxt = par_word[1];
      d30p_nxt = par_word[0];
    end
    wstart_nxt = load_r;
    strobe_nxt = load_r || (bit_tick && bit_cnt_r != nsf_pkg::WORD_LAST_BIT);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= nsf_pkg::ST_IDLE;
      div_r <= '0;
      bit_cnt_r <= 5'h0;
      word_idx_r <= 4'h1;
      sf_r <= nsf_pkg::SUBFRAME_RST;
      ebit_r <= 7'h0;
      tow_r <= nsf_pkg::TOW_RST;
      tx_word_r <= 30'h0;
      tx_data_r <= 24'h0;
      d29p_r <= 1'b0;
      d30p_r <= 1'b0;
      load_r <= 1'b0;
      strobe_r <= 1'b0;
      wstart_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      div_r <= div_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      word_idx_r <= word_idx_nxt;
      sf_r <= sf_nxt;
      ebit_r <= ebit_nxt;
      tow_r <= tow_nxt;
      tx_word_r <= tx_word_nxt;
      tx_data_r <= tx_data_nxt;
      d29p_r <= d29p_nxt;
      d30p_r <= d30p_nxt;
      load_r <= load_nxt;
      strobe_r <= strobe_nxt;
      wstart_r <= wstart_nxt;
    end
  end

  always_comb begin
    prdata = prdata_r;
    pready = pready_r;
    pslverr = pslverr_r;
    nav_bit = tx_word_r[29];
    bit_strobe = strobe_r;
    word_start = wstart_r;
    word_index = word_idx_r;
    subframe_id = sf_r;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_how_load;
    wstart_r && word_idx_r == 4'h2;
  endsequence

  sequence s_sf1_word3;
    wstart_r && word_idx_r == 4'h3 && sf_r == 3'h1;
  endsequence

  a_flag18_dump: assert property (s_how_load and !$past(ctrl_r.cfg001) |-> tx_data_r[6] == $past(dump_r))
    else $error("bit 18 differs from dump flag");
  a_dump_set_wins: assert property (momentum_dump |=> dump_r)
    else $error("dump event lost");
  a_flag18_alert: assert property (s_how_load and $past(ctrl_r.cfg001) |-> tx_data_r[6] == $past(ctrl_r.alert))
    else $error("bit 18 differs from alert");
  a_flag19_sync: assert property (s_how_load and !$past(ctrl_r.cfg001) |-> tx_data_r[5] == $past(ctrl_r.sync_lost))
    else $error("bit 19 differs from sync flag");
  a_flag19_spoof: assert property (s_how_load and $past(ctrl_r.cfg001) |-> tx_data_r[5] == $past(ctrl_r.antispoof))
    else $error("bit 19 differs from spoof flag");
  a_subframe_id: assert property (s_how_load |-> tx_data_r[4:2] == sf_r && sf_r >= 3'h1 && sf_r <= 3'h5)
    else $error("bad subframe id");
  a_week_field: assert property (s_sf1_word3 |-> tx_data_r[23:14] == $past(week_r))
    else $error("week field wrong");
  a_week_advance: assert property (week_inc && !wr |=> week_r == $past(week_r) + 10'h001)
    else $error("week did not advance");
  a_grade_field: assert property (s_sf1_word3 |-> tx_data_r[11:8] == active_r.grade)
    else $error("grade field wrong");
  a_health_field: assert property (s_sf1_word3 |-> tx_data_r[7:2] == active_r.health)
    else $error("health field wrong");
  a_issue_split: assert property (s_sf1_word3 |-> tx_data_r[1:0] == active_r.issue[9:8])
    else $error("issue msbs wrong");
  a_issue_reuse: assert property (commit_req && staged_r.issue == active_r.issue |=> err_r && $stable(active_r))
    else $error("reused issue accepted");
  a_gdelay_field: assert property (wstart_r && word_idx_r == 4'h7 && sf_r == 3'h1 |-> tx_data_r == {16'h0, active_r.gdelay})
    else $error("group delay wrong");
  a_bias_field: assert property (wstart_r && word_idx_r == 4'ha && sf_r == 3'h1 |-> tx_data_r[23:2] == active_r.bias)
    else $error("bias field wrong");
  a_reserved_zero: assert property (wstart_r && sf_r == 3'h1 && word_idx_r inside {4'h4, 4'h5, 4'h6} |-> tx_data_r == 24'h0)
    else $error("reserved word not zero");
  a_swap_frame: assert property (!$stable(active_r) |-> $past(frame_swap) && $past(pend_r))
    else $error("clock data changed mid frame");
  a_word_shape: assert property (load_r |=> wstart_r && strobe_r && bit_cnt_r == 5'h0 ##1 !wstart_r)
    else $error("word start malformed");
  a_how_tow: assert property (s_how_load |-> tx_data_r[23:7] == $past(tow_how[18:2]))
    else $error("handover count wrong");

endmodule
`default_nettype wire

//--- bench/nsf_rx_model.sv
// Receiver model: deserialises words and checks word parity.
// Assumes bit_strobe marks each new nav_bit and word_start bit one.
`timescale 1ns/100ps
`default_nettype none
module nsf_rx_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic nav_bit,
  input wire logic bit_strobe,
  input wire logic word_start,
  output logic word_done,
  output logic [23:0] word_data,
  output logic word_ok
);
  logic [29:0] sh_r;
  logic [4:0] cnt_r;
  logic d29_r, d30_r;
  wire logic [29:0] w = {sh_r[28:0], nav_bit};
  function automatic logic par_ok(input logic [29:0] x, input logic p29, input logic p30);
    logic [23:0] d;
    logic [5:0] p;
    d = x[29:6] ^ {24{p30}};
    p = {p29 ^ (^(d & nsf_pkg::PAR_MASK_25)), p30 ^ (^(d & nsf_pkg::PAR_MASK_26)),
         p29 ^ (^(d & nsf_pkg::PAR_MASK_27)), p30 ^ (^(d & nsf_pkg::PAR_MASK_28)),
         p30 ^ (^(d & nsf_pkg::PAR_MASK_29)), p29 ^ (^(d & nsf_pkg::PAR_MASK_30))};
    return p == x[5:0];
  endfunction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_r <= 30'h0;
      cnt_r <= 5'h0;
      d29_r <= 1'b0;
      d30_r <= 1'b0;
      word_done <= 1'b0;
      word_data <= 24'h0;
      word_ok <= 1'b0;
    end else begin
      word_done <= 1'b0;
      if (bit_strobe) begin
        sh_r <= w;
        cnt_r <= word_start ? 5'h1 : cnt_r + 5'h1;
        if (!word_start && cnt_r == 5'h1d) begin
          word_done <= 1'b1;
          word_data <= w[29:6] ^ {24{d30_r}};
          word_ok <= par_ok(w, d29_r, d30_r);
          d29_r <= w[1];
          d30_r <= w[0];
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/nav_subframe1_flag_decoder_test.sv
// Testbench: APB setup, then subframes decoded and compared.
// Assumes the framer with a short bit time and the receiver model.
`timescale 1ns/100ps
`default_nettype none
module nav_subframe1_flag_decoder_test;
  localparam logic [7:0] PRE = 8'h3c;
  logic pclk, presetn, psel, penable, pwrite, momentum_dump, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic pready, pslverr, nav_bit, bit_strobe, word_start, word_done, word_ok;
  logic [3:0] word_index;
  logic [2:0] subframe_id;
  logic [23:0] word_data;
  int n_mismatch = 0;
  int cmp_count = 0;
  nsf_framer #(.BIT_CYCLES(4), .PREAMBLE(PRE)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .momentum_dump(momentum_dump), .nav_bit(nav_bit),
    .bit_strobe(bit_strobe), .word_start(word_start), .word_index(word_index),
    .subframe_id(subframe_id));
  nsf_rx_model rx (.pclk(pclk), .presetn(presetn), .nav_bit(nav_bit), .bit_strobe(bit_strobe),
    .word_start(word_start), .word_done(word_done), .word_data(word_data), .word_ok(word_ok));
  task wrap_up();
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk iff pready === 1'b1);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rv & m, e);
  endtask
  task sf(input logic [2:0] id, input logic [16:0] handover_word, input logic b18, input logic b19,
          input logic [9:0] wk, input bit full);
    logic [23:0] e [1:10];
    logic drop;
    drop = 1'b0;
    for (int i = 1; i <= 10; i++) e[i] = 24'h0;
    e[1] = {PRE, 16'h0};
    e[2] = {handover_word, b18, b19, id, 2'b00};
    if (id == 3'h1) begin
      e[3] = {wk, 2'b00, 4'h9, 6'h21, 2'b10};
      e[7] = {16'h0, 8'h5a};
      e[8] = {8'hc3, 16'h1234};
      e[9] = {8'h7e, 16'hbeef};
      e[10] = {22'h2abcde, 2'b00};
    end
    for (int i = 1; i <= 10; i++) begin
      @(posedge pclk iff word_done === 1'b1);
      if (i > 1 || full) begin
        chk("word data", word_data, e[i]);
        chk("word parity", word_ok, 32'h1);
      end
      if (i == 2) begin
        drop = word_data[5];
      end
    end
    chk("sync drop", drop, b19);
  endtask
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    #2_000_000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    momentum_dump = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk("reset word", word_index, 32'h1);
    chk("reset subframe", subframe_id, 32'h1);
    rc(nsf_pkg::OFS_STATUS, 32'h7ff, 32'h48, "reset status");
    rc(8'h40, 32'hffffffff, 32'h0, "unmapped data");
    chk("unmapped err", er, 32'h1);
    apb(1'b1, nsf_pkg::OFS_WEEK, 32'h2a5);
    apb(1'b1, nsf_pkg::OFS_TOW, 32'h0);
    apb(1'b1, nsf_pkg::OFS_CLK_HEALTH, {12'h0, 10'h2c3, 6'h21, 4'h9});
    apb(1'b1, nsf_pkg::OFS_GROUP_DELAY, 32'h5a);
    apb(1'b1, nsf_pkg::OFS_CLK_REF, 32'h1234);
    apb(1'b1, nsf_pkg::OFS_DRIFT, {8'h0, 16'hbeef, 8'h7e});
    apb(1'b1, nsf_pkg::OFS_BIAS, 32'h2abcde);
    rc(nsf_pkg::OFS_CLK_HEALTH, 32'hfffff, {12'h0, 10'h2c3, 6'h21, 4'h9}, "staged set");
    apb(1'b1, nsf_pkg::OFS_CTRL, 32'h40);
    rc(nsf_pkg::OFS_STATUS, 32'h2, 32'h2, "commit pending");
    @(posedge pclk);
    momentum_dump <= 1'b1;
    @(posedge pclk);
    momentum_dump <= 1'b0;
    rc(nsf_pkg::OFS_STATUS, 32'h1, 32'h1, "dump flag");
    apb(1'b1, nsf_pkg::OFS_CTRL, 32'h9);
    for (int k = 1; k <= 5; k++) sf(k[2:0], k[16:0], 1'b1, 1'b1, 10'h2a5, 1'b1);
    apb(1'b1, nsf_pkg::OFS_CTRL, 32'h0);
    rc(nsf_pkg::OFS_STATUS, 32'h402, 32'h0, "busy after stop");
    apb(1'b1, nsf_pkg::OFS_CTRL, 32'h20);
    rc(nsf_pkg::OFS_STATUS, 32'h1, 32'h0, "dump cleared");
    apb(1'b1, nsf_pkg::OFS_CTRL, 32'h40);
    rc(nsf_pkg::OFS_STATUS, 32'h4, 32'h4, "issue reuse");
    apb(1'b1, nsf_pkg::OFS_STATUS, 32'h4);
    rc(nsf_pkg::OFS_STATUS, 32'h4, 32'h0, "reuse cleared");
    apb(1'b1, nsf_pkg::OFS_TOW, 32'h626fc);
    rc(nsf_pkg::OFS_TOW, 32'h7ffff, 32'h626fc, "epoch count");
    apb(1'b1, nsf_pkg::OFS_CTRL, 32'h17);
    sf(3'h1, 17'h0, 1'b1, 1'b1, 10'h2a5, 1'b0);
    sf(3'h1, 17'h1, 1'b1, 1'b1, 10'h2a6, 1'b1);
    rc(nsf_pkg::OFS_WEEK, 32'h3ff, 32'h2a6, "week after rollover");
    wrap_up();
  end
endmodule
`default_nettype wire
